// File: design/anr_pkg.sv
// constants for the auto-negotiation ability register bank
`default_nettype none
package anr_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam logic [4:0] DEV_ADDR = 5'h07;
  // register offsets inside management device 0x7
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_ADV = 6'h10;
  localparam logic [5:0] OFS_LP = 6'h13;
  localparam logic [5:0] OFS_XNP = 6'h16;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h30;
  localparam logic [5:0] OFS_IRQ_CLR = 6'h31;
  localparam logic [5:0] OFS_IRQ_EN = 6'h32;
  // reset values
  localparam logic [15:0] RST_CTRL = 16'h1000;
  localparam logic [15:0] RST_ADV = 16'h0101;
  localparam logic [15:0] RST_LP = 16'h0000;
  localparam logic [15:0] RST_XNP = 16'h2001;
  localparam logic [4:0] SELECTOR = 5'h01;
  // phy control fields
  localparam int CTL_SPD_LSB = 6;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_AN_EN = 12;
  localparam int CTL_SPD_MSB = 13;
  localparam logic [1:0] SPD_10 = 2'b00;
  localparam logic [1:0] SPD_100 = 2'b01;
  // ability field positions
  localparam int B_NP = 15;
  localparam int B_ACK = 14;
  localparam int B_RF = 13;
  localparam int B_XNP = 12;
  localparam int B_ASYM = 11;
  localparam int B_PAUSE = 10;
  localparam int B_T4 = 9;
  localparam int B_FFD = 8;
  localparam int B_FHD = 7;
  localparam int B_TFD = 6;
  localparam int B_THD = 5;
  // writable mask of local advertisement (selector bits are fixed)
  localparam logic [15:0] ADV_WMASK = 16'hbde0;
  // interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_PAGE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_NP = 2;
endpackage
`default_nettype wire

// File: design/anr_regs.sv
// auto-negotiation ability register bank with partner page capture
//
// Added by the designer: the address-and-strobe port.
`default_nettype none
module anr_regs (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [5:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_page_valid,
  input wire logic [15:0] i_page_data,
  output logic o_autoneg_en,
  output logic [15:0] o_adv,
  output logic [15:0] o_xnp_tx,
  output logic o_irq
);
  logic [15:0] ctrl;
  logic [15:0] adv_store;
  logic [15:0] xnp;
  logic [15:0] lp_page;
  logic [15:0] adv_view;
  logic [15:0] lp_view;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  logic [1:0] spd;
  logic dpx;
  logic an_on;
  logic [2:0] irq_evt;
  logic [2:0] irq_clr;
  logic [15:0] next_rdata;

  assign spd = {ctrl[anr_pkg::CTL_SPD_MSB], ctrl[anr_pkg::CTL_SPD_LSB]};
  assign dpx = ctrl[anr_pkg::CTL_DUPLEX];
  assign an_on = ctrl[anr_pkg::CTL_AN_EN];

  always_comb begin
    adv_view = adv_store;
    adv_view[4:0] = anr_pkg::SELECTOR;
    if (!an_on) begin
      adv_view[anr_pkg::B_FHD] = (spd == anr_pkg::SPD_100) && !dpx;
      adv_view[anr_pkg::B_FFD] = (spd == anr_pkg::SPD_100) && dpx;
      adv_view[anr_pkg::B_TFD] = (spd == anr_pkg::SPD_10) && dpx;
      adv_view[anr_pkg::B_THD] = (spd == anr_pkg::SPD_10) && !dpx;
    end
  end

  always_comb begin
    lp_view = lp_page;
    // forced link reports all four abilities
    if (!an_on) begin
      lp_view[anr_pkg::B_FFD:anr_pkg::B_THD] = 4'hf;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= anr_pkg::RST_CTRL;
    end else if (i_ce && i_wr && i_addr == anr_pkg::OFS_CTRL) begin
      ctrl <= i_wdata;
    end
  end

  // ten full/half bits stored at 6 and 5
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      adv_store <= anr_pkg::RST_ADV;
    end else if (i_ce && i_wr && i_addr == anr_pkg::OFS_ADV) begin
      adv_store <= i_wdata & anr_pkg::ADV_WMASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xnp <= anr_pkg::RST_XNP;
    end else if (i_ce && i_wr && i_addr == anr_pkg::OFS_XNP) begin
      xnp <= {i_wdata[15], 1'b0, i_wdata[13:12], xnp[11], i_wdata[10:0]};
    end
  end

  // capture only a whole received page; software cannot write
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lp_page <= anr_pkg::RST_LP;
    end else if (i_ce && i_page_valid) begin
      lp_page <= i_page_data;
    end
  end

  assign irq_evt[anr_pkg::IRQ_PAGE] = i_page_valid;
  assign irq_evt[anr_pkg::IRQ_FAULT] = i_page_valid && i_page_data[anr_pkg::B_RF];
  assign irq_evt[anr_pkg::IRQ_NP] = i_page_valid && i_page_data[anr_pkg::B_NP];
  assign irq_clr = (i_wr && i_addr == anr_pkg::OFS_IRQ_CLR) ? i_wdata[2:0] : 3'h0;

  // set wins over a clear in the same cycle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat <= 3'h0;
    end else if (i_ce) begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en <= 3'h0;
    end else if (i_ce && i_wr && i_addr == anr_pkg::OFS_IRQ_EN) begin
      irq_en <= i_wdata[2:0];
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    unique case (i_addr)
      anr_pkg::OFS_CTRL: next_rdata = ctrl;
      anr_pkg::OFS_ADV: next_rdata = adv_view;
      anr_pkg::OFS_LP: next_rdata = lp_view;
      anr_pkg::OFS_XNP: next_rdata = xnp;
      anr_pkg::OFS_IRQ_STAT: next_rdata = {13'h0000, irq_stat};
      anr_pkg::OFS_IRQ_EN: next_rdata = {13'h0000, irq_en};
      default: next_rdata = 16'h0000;
    endcase
  end

  // read data valid from the cycle after the strobe until the next enabled cycle; held while the enable is low
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_ce) begin
      o_rdata <= i_rd ? next_rdata : 16'h0000;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_autoneg_en <= anr_pkg::RST_CTRL[anr_pkg::CTL_AN_EN];
      o_adv <= anr_pkg::RST_ADV;
      o_xnp_tx <= anr_pkg::RST_XNP;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_autoneg_en <= an_on;
      o_adv <= adv_view;
      o_xnp_tx <= xnp;
      o_irq <= |(((irq_stat & ~irq_clr) | irq_evt) & irq_en);
    end
  end

  property p_fhd;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !an_on |-> adv_view[anr_pkg::B_FHD] == (spd == 2'b01 && !dpx);
  endproperty
  a_fhd: assert property (p_fhd) else $error("100 half forced wrong");
  property p_tfd;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !an_on |-> adv_view[anr_pkg::B_TFD] == (spd == 2'b00 && dpx);
  endproperty
  a_tfd: assert property (p_tfd) else $error("10 full forced wrong");
  property p_thd;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !an_on |-> adv_view[anr_pkg::B_THD] == (spd == 2'b00 && !dpx);
  endproperty
  a_thd: assert property (p_thd) else $error("10 half forced wrong");
  property p_sel;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_rd && i_addr == 6'h10 |=> o_rdata[4:0] == 5'h01;
  endproperty
  a_sel: assert property (p_sel) else $error("selector not fixed");
  property p_lp_ro;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && !i_page_valid |=> lp_page == $past(lp_page);
  endproperty
  a_lp_ro: assert property (p_lp_ro) else $error("partner page changed");
  property p_capture;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_page_valid |=> lp_page == $past(i_page_data);
  endproperty
  a_capture: assert property (p_capture) else $error("page not captured");
  property p_forced_lp;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_rd && i_addr == 6'h13 && !an_on |=> o_rdata[8:5] == 4'hf;
  endproperty
  a_forced_lp: assert property (p_forced_lp) else $error("forced bits not one");
  property p_lp_read;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_rd && i_addr == 6'h13 |=> o_rdata[15:9] == $past(lp_page[15:9]);
  endproperty
  a_lp_read: assert property (p_lp_read) else $error("partner high bits wrong");
  property p_xnp_rst;
    @(posedge i_mclk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> xnp == 16'h2001;
  endproperty
  a_xnp_rst: assert property (p_xnp_rst) else $error("transmit reset wrong");

  // raw control bits here, so a wrong field position in the package is caught
  property p_ffd;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !an_on |-> adv_view[8] == (!ctrl[13] && ctrl[6] && ctrl[8]);
  endproperty
  a_ffd: assert property (p_ffd) else $error("100 full forced wrong");

  property p_fhd_raw;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !an_on |-> adv_view[7] == (!ctrl[13] && ctrl[6] && !ctrl[8]);
  endproperty
  a_fhd_raw: assert property (p_fhd_raw) else $error("speed field bits wrong");

  property p_ctrl_wr;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_wr && i_addr == anr_pkg::OFS_CTRL |=> ctrl == $past(i_wdata);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  property p_adv_wr;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_wr && i_addr == anr_pkg::OFS_ADV |=> adv_store[6:5] == $past(i_wdata[6:5]);
  endproperty
  a_adv_wr: assert property (p_adv_wr) else $error("ten abilities not stored");

  property p_adv_auto;
    @(posedge i_mclk) disable iff (!i_rst_n)
      an_on |-> adv_view[8:5] == adv_store[8:5];
  endproperty
  a_adv_auto: assert property (p_adv_auto) else $error("stored abilities not shown");

  property p_sel_out;
    @(posedge i_mclk) disable iff (!i_rst_n)
      o_adv[4:0] == 5'h01;
  endproperty
  a_sel_out: assert property (p_sel_out) else $error("selector output moved");

  property p_lp_rst;
    @(posedge i_mclk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> lp_page == 16'h0000;
  endproperty
  a_lp_rst: assert property (p_lp_rst) else $error("partner reset wrong");

  property p_lp_wr;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_wr && i_addr == anr_pkg::OFS_LP && !i_page_valid
        |=> lp_page == $past(lp_page);
  endproperty
  a_lp_wr: assert property (p_lp_wr) else $error("partner register written");

  property p_np_stat;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_page_valid && i_page_data[15] |=> irq_stat[2];
  endproperty
  a_np_stat: assert property (p_np_stat) else $error("next-page status not set");

  property p_lp_ack;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_rd && i_addr == anr_pkg::OFS_LP |=> o_rdata[14] == $past(lp_page[14]);
  endproperty
  a_lp_ack: assert property (p_lp_ack) else $error("acknowledge bit wrong");

  property p_lp_fault;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_rd && i_addr == anr_pkg::OFS_LP |=> o_rdata[13] == $past(lp_page[13]);
  endproperty
  a_lp_fault: assert property (p_lp_fault) else $error("remote fault bit wrong");

  property p_fault_stat;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_page_valid && i_page_data[13] |=> irq_stat[1];
  endproperty
  a_fault_stat: assert property (p_fault_stat) else $error("fault status not set");

  property p_lp_pause;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_rd && i_addr == anr_pkg::OFS_LP |=> o_rdata[11:10] == $past(lp_page[11:10]);
  endproperty
  a_lp_pause: assert property (p_lp_pause) else $error("pause bits wrong");

  property p_lp_xnp;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_rd && i_addr == anr_pkg::OFS_LP
        |=> {o_rdata[12], o_rdata[9]} == $past({lp_page[12], lp_page[9]});
  endproperty
  a_lp_xnp: assert property (p_lp_xnp) else $error("t4 or extended bit wrong");

  property p_lp_speed;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_rd && i_addr == anr_pkg::OFS_LP && an_on
        |=> o_rdata[8:5] == $past(lp_page[8:5]);
  endproperty
  a_lp_speed: assert property (p_lp_speed) else $error("partner speed bits wrong");

  property p_lp_keep;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_rd && i_addr == anr_pkg::OFS_LP && !an_on
        |=> o_rdata[4:0] == $past(lp_page[4:0]);
  endproperty
  a_lp_keep: assert property (p_lp_keep) else $error("forcing spilled over");

  property p_lp_sel;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_rd && i_addr == anr_pkg::OFS_LP && an_on
        |=> o_rdata[4:0] == $past(lp_page[4:0]);
  endproperty
  a_lp_sel: assert property (p_lp_sel) else $error("partner selector altered");

  property p_xnp_wr;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_wr && i_addr == anr_pkg::OFS_XNP
        |=> xnp[14] == 1'b0 && xnp[11] == $past(xnp[11]);
  endproperty
  a_xnp_wr: assert property (p_xnp_wr) else $error("transmit fixed bits written");

  property p_xnp_rsv;
    @(posedge i_mclk) disable iff (!i_rst_n)
      xnp[14] == 1'b0;
  endproperty
  a_xnp_rsv: assert property (p_xnp_rsv) else $error("transmit reserved bit set");

  property p_xnp_out;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce |=> o_xnp_tx == $past(xnp);
  endproperty
  a_xnp_out: assert property (p_xnp_out) else $error("transmit output stale");

  property p_page_stat;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_page_valid |=> irq_stat[0];
  endproperty
  a_page_stat: assert property (p_page_stat) else $error("page status not set");

  property p_adv_out;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce |=> o_adv == $past(adv_view);
  endproperty
  a_adv_out: assert property (p_adv_out) else $error("advertisement output stale");

  property p_an_out;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce |=> o_autoneg_en == $past(an_on);
  endproperty
  a_an_out: assert property (p_an_out) else $error("autoneg output stale");

  property p_irq_out;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce |=> o_irq == |(irq_stat & $past(irq_en));
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt level wrong");

  property p_rdata_idle;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && !i_rd |=> o_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

  property p_ce_freeze;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !i_ce |=> $stable(ctrl) && $stable(adv_store) && $stable(xnp)
        && $stable(lp_page) && $stable(irq_stat) && $stable(irq_en)
        && $stable(o_rdata) && $stable(o_irq);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

  property p_clr;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_wr && i_addr == anr_pkg::OFS_IRQ_CLR && !i_page_valid
        |=> (irq_stat & $past(i_wdata[2:0])) == 3'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("status clear lost");
endmodule
`default_nettype wire

// File: testbench/anr_link_partner.sv
// link partner model that hands over one base page per request
`default_nettype none
module anr_link_partner (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_send,
  input wire logic [15:0] i_page,
  output logic o_page_valid,
  output logic [15:0] o_page_data
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_page_valid <= 1'b0;
      o_page_data <= 16'h0000;
    end else if (i_send) begin
      o_page_valid <= 1'b1;
      o_page_data <= {i_page[15:5], 5'h01};
    end else begin
      o_page_valid <= 1'b0;
      // no page on the lines: toggling data exposes a capture outside the pulse
      o_page_data <= ~o_page_data;
    end
  end
endmodule
`default_nettype wire

// File: testbench/anr_regs_tb.sv
// self-checking bench for the auto-negotiation ability registers
`default_nettype none
module anr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] ctl; logic [15:0] adv;} anr_row_t;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic snd = 1'b0;
  logic ce = 1'b1;
  logic [5:0] i_addr = 6'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] pg = 16'h0000;
  logic pv;
  logic o_autoneg_en;
  logic o_irq;
  logic [15:0] pd;
  logic [15:0] o_rdata;
  logic [15:0] o_adv;
  logic [15:0] o_xnp_tx;
  int n_fail = 0;
  int n_compared = 0;
  // forced speed {bit13,bit6} and duplex bit8, autoneg off; advertisement cleared first
  anr_row_t rows [6] = '{
    '{16'h0000, 16'h0021}, '{16'h0100, 16'h0041}, '{16'h0040, 16'h0081},
    '{16'h0140, 16'h0101}, '{16'h2000, 16'h0001}, '{16'h2140, 16'h0001}};
  initial forever #5 i_mclk = ~i_mclk;
  anr_regs anr_regs_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_page_valid(pv),
    .i_page_data(pd), .o_autoneg_en(o_autoneg_en), .o_adv(o_adv), .o_xnp_tx(o_xnp_tx),
    .o_irq(o_irq));
  anr_link_partner anr_link_partner_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_send(snd),
    .i_page(pg), .o_page_valid(pv), .o_page_data(pd));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task automatic send(input logic [15:0] p);
    @(posedge i_mclk);
    snd <= 1'b1;
    pg <= p;
    @(posedge i_mclk);
    snd <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    wr(anr_pkg::OFS_ADV, 16'h0000);
    send(16'he5a1);
    rd(anr_pkg::OFS_IRQ_STAT, 16'h0007);
    foreach (rows[i]) begin
      wr(anr_pkg::OFS_CTRL, rows[i].ctl);
      rd(anr_pkg::OFS_ADV, rows[i].adv);
      chk(o_adv, rows[i].adv);
      chk({15'h0000, o_autoneg_en}, 16'h0000);
      rd(anr_pkg::OFS_LP, 16'he5e1);
    end
    $display("forced ability test done");
    wr(anr_pkg::OFS_CTRL, 16'h1000);
    wr(anr_pkg::OFS_ADV, 16'hffff);
    rd(anr_pkg::OFS_ADV, 16'hbde1);
    rd(anr_pkg::OFS_LP, 16'he5a1);
    wr(anr_pkg::OFS_IRQ_EN, 16'h0007);
    wr(anr_pkg::OFS_IRQ_CLR, 16'h0007);
    send(16'h1a5f);
    rd(anr_pkg::OFS_LP, 16'h1a41);
    rd(anr_pkg::OFS_IRQ_STAT, 16'h0001);
    chk({15'h0000, o_irq}, 16'h0001);
    wr(anr_pkg::OFS_IRQ_EN, 16'h0000);
    repeat (2) @(posedge i_mclk);
    #1 chk({15'h0000, o_irq}, 16'h0000);
    wr(anr_pkg::OFS_IRQ_EN, 16'h0001);
    wr(anr_pkg::OFS_IRQ_CLR, 16'h0001);
    repeat (2) @(posedge i_mclk);
    #1 chk({15'h0000, o_irq}, 16'h0000);
    rd(anr_pkg::OFS_IRQ_STAT, 16'h0000);
    $display("page and interrupt test done");
    // read-only partner view and an unmapped offset
    wr(anr_pkg::OFS_LP, 16'hffff);
    rd(anr_pkg::OFS_LP, 16'h1a41);
    rd(6'h3f, 16'h0000);
    // a write while the enable is low must leave no trace
    @(posedge i_mclk);
    ce <= 1'b0;
    wr(anr_pkg::OFS_ADV, 16'h0000);
    ce <= 1'b1;
    rd(anr_pkg::OFS_ADV, 16'hbde1);
    wr(anr_pkg::OFS_XNP, 16'hffff);
    rd(anr_pkg::OFS_XNP, 16'hb7ff);
    chk(o_xnp_tx, 16'hb7ff);
    $display("access test done");
    // reset in mid-run must restore the partner, extended next page and advertisement registers
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(anr_pkg::OFS_LP, 16'h0000);
    rd(anr_pkg::OFS_XNP, 16'h2001);
    chk(o_xnp_tx, 16'h2001);
    rd(anr_pkg::OFS_ADV, 16'h0101);
    chk(o_adv, 16'h0101);
    $display("reset test done");
    print_verdict();
  end
endmodule
`default_nettype wire
